/* File: sww_pkg.sv */
// Purpose: constants and types for the supervisor / wake-up / watchdog block
// Assumes: core_clk at 20 MHz; all analog comparators arrive as digital levels
// Notes:   times are kept in ns and turned into cycle counts here
// Contract
// - flag low-voltage below undervoltage threshold, high-voltage above overvoltage threshold
// - flag over-temperature prewarning ahead of regulator thermal shutdown
// - LIN overtemp, TXD stuck, RXD short disable driver until gone and read
// - LIN over-current sets its flag and keeps the driver enabled
// - separate interrupt sources for high-side and low-side thermal shutdown
// - hold reset pin low during any reset condition, then 1 ms more
// - regulator output below reset threshold issues a reset
// - regulator over-temperature disables regulator and sets its flag regardless of voltage
// - filtered low on reset pin holds reset-mode safe state, also in stop
// - externally released reset pin adds no extension delay
// - stop wake by interrupt, sleep wake by full reset; source readable
// - per-input wake enables; present wake input states reported
// - wake input selected in analog mux cannot wake the device
// - cyclic sense samples periodically, wakes on change; exclusive with forced wake
// - chip-select rising edge wakes from stop with no interrupt or flag
// - LIN wake needs long dominant pulse then recessive; stuck dominant never wakes
// - filtered reset-pin low in stop wakes silently to normal-request or normal
// - mode writes clear watchdog; early clear or timeout resets; prescaler set
// - grounded watchdog config disables watchdog, skips normal-request, sampled in reset
// - open watchdog config uses internal 150 ms timebase and flags fault
// - normal-request has no window; 150 ms without normal command resets
// - interrupt pin low while pending, high after the source read
// - no interrupt while reset pin is low
// - interrupt enable mask keeps masked sources off the interrupt pin
package sww_pkg;

    localparam int unsigned CLK_PERIOD_NS = 50;

    localparam int unsigned RST_EXT_NS    = 1000000;
    localparam int unsigned NR_TIMEOUT_NS = 150000000;
    localparam int unsigned WD_INT_NS     = 150000000;
    localparam int unsigned WD_RES_NS     = 10000000;
    localparam int unsigned GLITCH_NS     = 10000;
    localparam int unsigned LIN_WAKE_NS   = 100000;
    localparam int unsigned CYC_BASE_NS   = 10000000;
    localparam int unsigned SAMPLE_NS     = 800;

    // least times round up, longest times round down
    localparam int unsigned RST_EXT_CYC   = (RST_EXT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned NR_TO_CYC     = NR_TIMEOUT_NS / CLK_PERIOD_NS;
    localparam int unsigned WD_INT_CYC    = WD_INT_NS / CLK_PERIOD_NS;
    localparam int unsigned WD_RES_CYC    = WD_RES_NS / CLK_PERIOD_NS;
    localparam int unsigned GLITCH_CYC    = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned LIN_WAKE_CYC  = (LIN_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CYC_BASE_CYC  = CYC_BASE_NS / CLK_PERIOD_NS;
    localparam int unsigned SAMPLE_CYC    = (SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int unsigned TMR_W = 26;

    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_STOP   = 2'h1;
    localparam logic [1:0] MODE_SLEEP  = 2'h2;

    localparam int unsigned INT_LOWV = 0;
    localparam int unsigned INT_HIGHV = 1;
    localparam int unsigned INT_PREW = 2;
    localparam int unsigned INT_LIN  = 3;
    localparam int unsigned INT_HS   = 4;
    localparam int unsigned INT_LS   = 5;
    localparam int unsigned INT_WAKE = 6;
    localparam int unsigned INT_W    = 7;

    localparam int unsigned WK_LX    = 0;
    localparam int unsigned WK_LIN   = 1;
    localparam int unsigned WK_TIMER = 2;
    localparam int unsigned WK_W     = 3;

    localparam int unsigned LF_OT    = 0;
    localparam int unsigned LF_TXD   = 1;
    localparam int unsigned LF_RXD   = 2;

    typedef enum logic [2:0] {
        SWW_RESET,
        SWW_NORMREQ,
        SWW_NORMAL,
        SWW_STOP,
        SWW_SLEEP
    } sww_mode_e;

endpackage

/* File: sww_sync.sv */
// Purpose: two-stage synchroniser for a vector of asynchronous levels
// Assumes: bits are independent levels; no bus coherency needed
// Notes:   reset value chosen per instance to match the idle pin level
module sww_sync #(
    parameter int unsigned         WIDTH = 1,
    parameter logic [WIDTH-1:0]    RV    = '0
) (
    input  wire logic              core_clk, // clock
    input  wire logic              rst_b,    // async reset
    input  wire logic [WIDTH-1:0]  din,      // raw levels
    output logic      [WIDTH-1:0]  dout      // synchronised levels
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            stage1 <= RV;
            dout   <= RV;
        end
        else
        begin
            stage1 <= din;
            dout   <= stage1;
        end
    end
endmodule // sww_sync

/* File: sww_timer.sv */
// Purpose: saturating up-counter; clears whenever run is low
// Assumes: limit is stable while run is high
// Notes:   done is a level that holds while run stays high after reaching limit
module sww_timer #(
    parameter int unsigned W = 26
) (
    input  wire logic          core_clk, // clock
    input  wire logic          rst_b,    // async reset
    input  wire logic          run,      // count while high
    input  wire logic [W-1:0]  limit,    // terminal count
    output logic      [W-1:0]  count,    // elapsed cycles
    output logic               done      // count reached limit
);
    if (W < 2)
    begin : g_chk
        $error("sww_timer: W too small");
    end

    assign done = (count == limit);

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            count <= '0;
        else if (!run)
            count <= '0;
        else if (!done)
            count <= count + W'(1);
    end
endmodule // sww_timer

/* File: sww_supervisor.sv */
// Purpose: mode sequencer, reset pin, interrupts, wake-up and window watchdog
// Assumes: SPI decoding lives outside; reads and mode writes arrive as 1-cycle pulses
// Notes:   reset pin is open-drain, low only; pin levels pass two flip-flops first
module sww_supervisor
    import sww_pkg::*;
#(
    parameter int unsigned RST_EXT  = RST_EXT_CYC,
    parameter int unsigned NR_TO    = NR_TO_CYC,
    parameter int unsigned WD_INT   = WD_INT_CYC,
    parameter int unsigned WD_RES   = WD_RES_CYC,
    parameter int unsigned CYC_BASE = CYC_BASE_CYC,
    parameter int unsigned LIN_WAKE = LIN_WAKE_CYC,
    parameter int unsigned GLITCH   = GLITCH_CYC,
    parameter int unsigned N_WAKE   = 4
) (
    input  wire logic              core_clk,       // 20 MHz clock
    input  wire logic              rst_b,          // async reset, active low
    input  wire logic              supplyUnderIn,  // battery below undervoltage threshold
    input  wire logic              supplyOverIn,   // battery above overvoltage threshold
    input  wire logic              preWarnIn,      // temperature prewarning
    input  wire logic              linOverTempIn,  // LIN driver over-temperature
    input  wire logic              txdStuckIn,     // transmit line stuck dominant
    input  wire logic              rxdShortIn,     // receive line short
    input  wire logic              linOverCurIn,   // LIN over-current
    input  wire logic              hsOverTempIn,   // high-side thermal shutdown
    input  wire logic              lsOverTempIn,   // low-side thermal shutdown
    input  wire logic              regLowIn,       // regulator below reset threshold
    input  wire logic              regOverTempIn,  // regulator over-temperature
    input  wire logic              wdConfGndIn,    // watchdog config pin grounded
    input  wire logic              wdConfOpenIn,   // watchdog config pin open
    input  wire logic              linDominantIn,  // LIN bus dominant
    input  wire logic              csPin_b,        // SPI chip select pin
    input  wire logic              rstPinIn,       // reset pin level
    input  wire logic [N_WAKE-1:0] wakeIn,         // wake input levels
    input  wire logic              modeWrite,      // mode bits written (pulse)
    input  wire logic [1:0]        modeBits,       // mode code written
    input  wire logic              cyclicSelect,   // timer in cyclic/forced mode
    input  wire logic [1:0]        periodSelect,   // cyclic period select
    input  wire logic [1:0]        wdPrescale,     // watchdog prescaler
    input  wire logic [N_WAKE-1:0] wakeEnable,     // per-input wake enable
    input  wire logic [N_WAKE-1:0] muxSelect,      // input routed to analog mux
    input  wire logic [1:0]        hsEnable,       // high-side switch enables
    input  wire logic [INT_W-1:0]  intEnable,      // interrupt mask, 1 = enabled
    input  wire logic              srcRead,        // source register read (pulse)
    input  wire logic              linStatusRead,  // LIN status read (pulse)
    input  wire logic              wakeStatusRead, // wake status read (pulse)
    output logic                   irqPin_b,       // interrupt pin, low = pending
    output logic                   rstPinOut,      // reset pin drive level
    output logic                   rstPinOe,       // reset pin driven low
    output logic                   regEnable,      // main regulator on
    output logic                   linDrvEnable,   // LIN transmitter enabled
    output logic                   hsCyclicOn,     // high side on for sensing
    output sww_mode_e              modeNow,        // present mode
    output logic [INT_W-1:0]       intSource,      // latched interrupt sources
    output logic [2:0]             linFault,       // latched LIN driver faults
    output logic                   linOcFlag,      // latched LIN over-current
    output logic                   regOtFlag,      // latched regulator overtemp
    output logic [WK_W-1:0]        wakeSource,     // latched wake source
    output logic [N_WAKE-1:0]      wakeInState,    // present wake input states
    output logic                   wdOffFlag,      // watchdog disabled by pin
    output logic                   wdFaultFlag     // watchdog timebase fault
);
    // the pin reads low two cycles after we release it; a shorter filter would trip
    if ((WD_INT << 3) >= (1 << TMR_W) || (CYC_BASE << 3) >= (1 << TMR_W) ||
        NR_TO >= (1 << TMR_W) || RST_EXT == 0 || GLITCH < 3)
    begin : g_chk
        $error("sww_supervisor: timing parameter out of range");
    end

    localparam logic [TMR_W-1:0] L_RST_EXT  = TMR_W'(RST_EXT);
    localparam logic [TMR_W-1:0] L_NR_TO    = TMR_W'(NR_TO);
    localparam logic [TMR_W-1:0] L_GLITCH   = TMR_W'(GLITCH);
    localparam logic [TMR_W-1:0] L_LIN_WAKE = TMR_W'(LIN_WAKE);
    localparam logic [7:0]       L_SAMPLE   = 8'(SAMPLE_CYC);

    logic [13:0]       syncA;
    logic [1:0]        syncB;
    logic              uvS, ovS, pwS, linOtS, txdS, rxdS, linOcS;
    logic              hsOtS, lsOtS, regLowS, regOtS, wdGndS, wdOpenS, linDomS;
    logic              csS, rstS, csPrev;
    logic              extMode, next_extMode;
    sww_mode_e         next_mode;
    logic [N_WAKE-1:0] snap;
    logic [7:0]        sampleCnt;

    sww_sync #(.WIDTH(14), .RV(14'h0000)) u_syncA (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .din      ({supplyUnderIn, supplyOverIn, preWarnIn, linOverTempIn, txdStuckIn,
                    rxdShortIn, linOverCurIn, hsOverTempIn, lsOverTempIn, regLowIn,
                    regOverTempIn, wdConfGndIn, wdConfOpenIn, linDominantIn}),
        .dout     (syncA)
    );
    sww_sync #(.WIDTH(N_WAKE), .RV('0)) u_syncW (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .din      (wakeIn),
        .dout     (wakeInState)
    );
    sww_sync #(.WIDTH(2), .RV(2'h3)) u_syncB (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .din      ({csPin_b, rstPinIn}),
        .dout     (syncB)
    );
    assign {uvS, ovS, pwS, linOtS, txdS, rxdS, linOcS, hsOtS, lsOtS, regLowS,
            regOtS, wdGndS, wdOpenS, linDomS} = syncA;
    assign {csS, rstS} = syncB;

    wire lowPower = (modeNow == SWW_STOP) || (modeNow == SWW_SLEEP);

    // glitch filter; our own drive is not taken for an external reset
    logic rstLowF;
    sww_timer #(.W(TMR_W)) u_glitch (
        .core_clk (core_clk), .rst_b (rst_b),
        .run      (!rstS && !rstPinOe), .limit (L_GLITCH),
        .count    (), .done (rstLowF)
    );

    // extension counts only once the internal cause is gone
    logic extDone;
    sww_timer #(.W(TMR_W)) u_ext (
        .core_clk (core_clk), .rst_b (rst_b),
        .run      (modeNow == SWW_RESET && !extMode && !regLowS), .limit (L_RST_EXT),
        .count    (), .done (extDone)
    );

    logic nrTimeout;
    sww_timer #(.W(TMR_W)) u_nr (
        .core_clk (core_clk), .rst_b (rst_b),
        .run      (modeNow == SWW_NORMREQ), .limit (L_NR_TO),
        .count    (), .done (nrTimeout)
    );

    // internal timebase when the config pin is open
    wire [TMR_W-1:0] wdBase   = wdFaultFlag ? TMR_W'(WD_INT) : TMR_W'(WD_RES);
    wire [TMR_W-1:0] wdPeriod = wdBase << wdPrescale;
    wire             wdClr    = modeWrite && modeBits == MODE_NORMAL && modeNow == SWW_NORMAL;
    logic [TMR_W-1:0] wdCount;
    logic             wdOvf;
    sww_timer #(.W(TMR_W)) u_wd (
        .core_clk (core_clk), .rst_b (rst_b),
        .run      (modeNow == SWW_NORMAL && !wdOffFlag && !wdClr), .limit (wdPeriod),
        .count    (wdCount), .done (wdOvf)
    );
    // closed first half, overflow after the full period
    wire wdFail = modeNow == SWW_NORMAL && !wdOffFlag &&
                  (wdOvf || (wdClr && wdCount < (wdPeriod >> 1)));

    // dominant must outlast the minimum before release counts
    logic linLong;
    sww_timer #(.W(TMR_W)) u_lin (
        .core_clk (core_clk), .rst_b (rst_b),
        .run      (lowPower && linDomS), .limit (L_LIN_WAKE),
        .count    (), .done (linLong)
    );
    wire linWake = lowPower && !linDomS && linLong;

    // period timer shared by cyclic sense and forced wake
    logic perEnd;
    sww_timer #(.W(TMR_W)) u_cyc (
        .core_clk (core_clk), .rst_b (rst_b),
        .run      (lowPower && cyclicSelect && !perEnd),
        .limit    (TMR_W'(CYC_BASE) << periodSelect),
        .count    (), .done (perEnd)
    );

    // mux-selected inputs are excluded from wake
    wire lxChange  = |((wakeInState ^ snap) & wakeEnable & ~muxSelect);
    wire lxWake    = lowPower && !cyclicSelect && lxChange;
    // sampling only while the high side is on, judged at its end
    wire cycWake   = lowPower && hsCyclicOn && sampleCnt == 8'h01 && lxChange;
    // no high side enabled selects forced wake, so both cannot run
    wire forceWake = lowPower && cyclicSelect && perEnd && hsEnable == 2'h0;
    // chip-select rising edge, stop only, nothing recorded
    wire csWake    = modeNow == SWW_STOP && csS && !csPrev;
    wire flagWake  = lxWake || cycWake || forceWake || linWake;
    wire exitMode  = wdGndS ? 1'b1 : 1'b0;

    always_comb
    begin
        next_mode = modeNow;
        unique case (modeNow)
            SWW_RESET:
                if (extMode ? !rstLowF : extDone)
                    next_mode = exitMode ? SWW_NORMAL : SWW_NORMREQ;
            SWW_NORMREQ:
                if (nrTimeout)
                    next_mode = SWW_RESET;
                else if (modeWrite && modeBits == MODE_NORMAL)
                    next_mode = SWW_NORMAL;
            SWW_NORMAL:
                if (wdFail)
                    next_mode = SWW_RESET;
                else if (modeWrite && modeBits == MODE_STOP)
                    next_mode = SWW_STOP;
                else if (modeWrite && modeBits == MODE_SLEEP)
                    next_mode = SWW_SLEEP;
            SWW_STOP:
                if (flagWake || csWake)
                    next_mode = wdOffFlag ? SWW_NORMAL : SWW_NORMREQ;
            SWW_SLEEP:
                // sleep wake goes through a full reset
                if (flagWake)
                    next_mode = SWW_RESET;
        endcase
        // regulator is off in sleep, so its monitor and the pin are ignored there
        if (modeNow != SWW_SLEEP)
        begin
            // external reset holds the safe state, stop included
            // a reset-pin wake from stop takes this path, silently
            if (rstLowF)
                next_mode = SWW_RESET;
            else if (regLowS)
                next_mode = SWW_RESET;
        end
    end

    assign next_extMode = (next_mode == SWW_RESET) && rstLowF && !regLowS;

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            modeNow   <= SWW_RESET;
            extMode   <= 1'b0;
            rstPinOe  <= 1'b1;
            rstPinOut <= 1'b0;
            csPrev    <= 1'b1;
        end
        else
        begin
            modeNow   <= next_mode;
            extMode   <= next_extMode;
            // pin held low for the whole internal reset
            rstPinOe  <= (next_mode == SWW_RESET) && !next_extMode;
            rstPinOut <= 1'b0;
            csPrev    <= csS;
        end
    end

    // watchdog strap caught only while in reset mode
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wdOffFlag   <= 1'b0;
            wdFaultFlag <= 1'b0;
        end
        else if (modeNow == SWW_RESET)
        begin
            wdOffFlag   <= wdGndS;
            wdFaultFlag <= wdOpenS;
        end
    end

    // snapshot on entry, high side pulsed at each period end
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            snap       <= '0;
            hsCyclicOn <= 1'b0;
            sampleCnt  <= 8'h00;
        end
        else
        begin
            if (!lowPower)
                snap <= wakeInState;
            if (lowPower && cyclicSelect && perEnd && hsEnable != 2'h0)
            begin
                hsCyclicOn <= 1'b1;
                sampleCnt  <= L_SAMPLE;
            end
            else if (sampleCnt > 8'h01 && lowPower)
                sampleCnt <= sampleCnt - 8'h01;
            else
            begin
                hsCyclicOn <= 1'b0;
                sampleCnt  <= 8'h00;
            end
        end
    end

    wire [2:0] linCond   = {rxdS, txdS, linOtS};
    wire       intModeOk = modeNow == SWW_NORMAL || modeNow == SWW_NORMREQ ||
                           modeNow == SWW_STOP;
    wire [INT_W-1:0] intSet;
    assign intSet[INT_LOWV]  = intModeOk && uvS;
    assign intSet[INT_HIGHV] = intModeOk && ovS;
    assign intSet[INT_PREW]  = intModeOk && pwS;
    assign intSet[INT_LIN]   = intModeOk && (|linCond || linOcS);
    // high side and low side kept apart
    assign intSet[INT_HS]    = intModeOk && hsOtS;
    assign intSet[INT_LS]    = intModeOk && lsOtS;
    // stop wake raises the wake interrupt, chip select excluded
    assign intSet[INT_WAKE]  = modeNow == SWW_STOP && flagWake;

    wire [2:0] next_linFault = (linFault & ~({3{linStatusRead}} & ~linCond)) | linCond;
    wire [WK_W-1:0] wakeSet  = {forceWake, linWake, lxWake || cycWake};
    // reset pin low blocks the interrupt
    wire irqAllowed = intModeOk && !rstLowF && !rstPinOe;

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            intSource    <= '0;
            linFault     <= 3'h0;
            linOcFlag    <= 1'b0;
            regOtFlag    <= 1'b0;
            wakeSource   <= '0;
            linDrvEnable <= 1'b1;
            regEnable    <= 1'b1;
            irqPin_b     <= 1'b1;
        end
        else
        begin
            // sticky until read; a new event wins over the clear
            intSource    <= (intSource & ~{INT_W{srcRead}}) | intSet;
            // latched until read with the cause gone
            linFault     <= next_linFault;
            linDrvEnable <= ~|next_linFault;
            // over-current only flags, driver stays on
            linOcFlag    <= (linOcFlag & ~linStatusRead) | linOcS;
            // overtemp flag independent of output voltage
            regOtFlag    <= (regOtFlag & ~srcRead) | regOtS;
            // regulator off on overtemp and in sleep
            regEnable    <= !regOtS && next_mode != SWW_SLEEP;
            // wake source kept across the reset sequence
            wakeSource   <= (wakeSource & ~{WK_W{wakeStatusRead}}) | wakeSet;
            // low while an enabled source is pending
            // only enabled sources reach the pin
            irqPin_b     <= !(irqAllowed && |((intSource & ~{INT_W{srcRead}}) & intEnable));
        end
    end
endmodule // sww_supervisor

/* File: sww_supervisor_props.sv */
// Purpose: port checker for sww_supervisor
// Assumes: one clock domain
// Notes: bound to every instance
module sww_supervisor_props
    import sww_pkg::*;
(
    input wire logic       core_clk,       // clock
    input wire logic       rst_b,          // reset
    input wire logic       wakeStatusRead, // wake read
    input wire logic [6:0] intEnable,      // mask
    input wire logic       irqPin_b,       // irq
    input wire logic       rstPinOe,       // reset drive
    input wire logic       regEnable,      // regulator
    input wire logic       linDrvEnable,   // lin driver
    input wire sww_mode_e  modeNow,        // mode
    input wire logic [6:0] intSource,      // sources
    input wire logic [2:0] linFault,       // lin faults
    input wire logic       linOcFlag,      // overcurrent
    input wire logic [2:0] wakeSource      // wake source
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    sequence s_sleep_left;
        modeNow == SWW_SLEEP ##1 modeNow != SWW_SLEEP;
    endsequence
    a_drv_follows: assert property (linDrvEnable == (linFault == 3'h0))
        else $error("lin driver enable wrong");
    a_oc_keeps: assert property ($rose(linOcFlag) && linFault == 3'h0 |-> linDrvEnable)
        else $error("overcurrent dropped driver");
    a_irq_quiet: assert property (rstPinOe |=> irqPin_b)
        else $error("irq during reset");
    a_mask_quiet: assert property ((intSource & intEnable) == 7'h0 |=> irqPin_b)
        else $error("masked irq");
    a_sleep_off: assert property (modeNow == SWW_SLEEP |-> !regEnable)
        else $error("regulator on in sleep");
    a_sleep_reset: assert property (s_sleep_left |-> modeNow == SWW_RESET)
        else $error("sleep wake skipped reset");
    a_wake_held: assert property ($fell(|wakeSource) |-> $past(wakeStatusRead))
        else $error("wake source lost unread");
    a_reset_drive: assert property ($fell(rstPinOe) |-> modeNow != SWW_RESET)
        else $error("reset released early");
endmodule // sww_supervisor_props

bind sww_supervisor sww_supervisor_props u_sww_supervisor_props (.*);

/* File: sww_mcu_model.sv */
// Purpose: controller side of reset and irq pins
// Assumes: reset wire has a pull-up
// Notes: reads the sources once per low irq
module sww_mcu_model (
    input  wire logic core_clk, // clock
    input  wire logic rstPinOe, // device pulls low
    input  wire logic irqPin_b, // irq pin
    input  wire logic holdLow,  // we pull low
    input  wire logic ackOn,    // service irq
    output logic      rstPinIn, // wire level
    output logic      srcRead   // read pulse
);
    timeunit 1ns;
    timeprecision 1ns;
    assign rstPinIn = !(rstPinOe || holdLow);
    always @(posedge core_clk)
        srcRead <= ackOn && !irqPin_b && srcRead === 1'b0;
endmodule // sww_mcu_model

/* File: supervisor_wakeup_watchdog_test.sv */
// Purpose: bench for sww_supervisor
// Assumes: watchdog pin grounded, short counts
// Notes: partner resolves the reset wire
module supervisor_wakeup_watchdog_test
    import sww_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk, rst_b, preWarnIn, supplyOverIn, supplyUnderIn, linOverTempIn, txdStuckIn;
    logic rxdShortIn, linOverCurIn, hsOverTempIn, lsOverTempIn, regLowIn, regOverTempIn;
    logic wdConfGndIn, wdConfOpenIn, linDominantIn, csPin_b, rstPinIn, modeWrite, cyclicSelect;
    logic srcRead, linStatusRead, wakeStatusRead, holdLow, ackOn, irqPin_b, rstPinOut, rstPinOe;
    logic regEnable, linDrvEnable, hsCyclicOn, linOcFlag, regOtFlag, wdOffFlag, wdFaultFlag;
    logic [3:0] wakeIn, wakeEnable, muxSelect, wakeInState;
    logic [1:0] modeBits, periodSelect, wdPrescale, hsEnable;
    logic [6:0] intEnable, intSource, cause;
    logic [2:0] linFault, wakeSource;
    sww_mode_e  modeNow;
    int         err_total, n_checks, cyc, n;
    assign {linOverCurIn, lsOverTempIn, hsOverTempIn, linOverTempIn, preWarnIn, supplyOverIn,
        supplyUnderIn} = cause;
    sww_supervisor #(.RST_EXT(20), .WD_RES(64), .CYC_BASE(64), .GLITCH(4)) u_sww_supervisor (.*);
    sww_mcu_model u_sww_mcu_model (.*);
    initial core_clk = 1'b0;
    always #25 core_clk = ~core_clk;
    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 4000)
        begin
            err_total++;
            results();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        n_checks++;
        if (seen !== want)
        begin
            err_total++;
            $display("BAD %0t seen %h want %h", $time, seen, want);
        end
    endtask
    task automatic step(input int k);
        repeat (k) @(posedge core_clk);
    endtask
    task automatic set_mode(input logic [1:0] c);
        modeBits <= c;
        modeWrite <= 1'b1;
        step(1);
        modeWrite <= 1'b0;
        step(3);
    endtask
    task automatic t_irq;
        for (int i = 0; i < 7; i++)
        begin
            cause <= 7'h1 << i;
            step(6);
            chk(intSource[i == 6 ? 3 : i], 1'b1);
            chk({irqPin_b, linDrvEnable, linOcFlag, linFault},
                {1'b0, i != 3, i == 6, 2'h0, i == 3});
            cause <= 7'h0;
            ackOn <= 1'b1;
            step(8);
            linStatusRead <= 1'b1;
            step(1);
            {linStatusRead, ackOn} <= 2'h0;
            step(2);
            chk({irqPin_b, linDrvEnable, linOcFlag}, 3'h6);
        end
        $display("sources done");
    endtask
    task automatic t_ext;
        {regOverTempIn, intEnable} <= 8'hfe;
        cause <= 7'h1;
        step(6);
        chk({intSource[0], irqPin_b, regOtFlag, regEnable}, 4'he);
        {regOverTempIn, holdLow, cause} <= 9'h082;
        step(12);
        chk({modeNow, rstPinOe, irqPin_b}, {SWW_RESET, 2'h1});
        holdLow <= 1'b0;
        step(7);
        chk(modeNow, SWW_NORMAL);
        {ackOn, cause, intEnable} <= 15'h407f;
        step(8);
        ackOn <= 1'b0;
        $display("external reset done");
    endtask
    task automatic t_sleep;
        {cyclicSelect, hsEnable, periodSelect} <= 5'h10;
        set_mode(MODE_SLEEP);
        chk({modeNow, regEnable, hsCyclicOn, regOtFlag, wakeInState}, {SWW_SLEEP, 7'h0});
        for (n = 0; n < 200 && modeNow !== SWW_NORMAL; n++)
            step(1);
        chk(wakeSource, 3'h4);
        wakeStatusRead <= 1'b1;
        step(1);
        {wakeStatusRead, cyclicSelect} <= 2'h0;
        set_mode(MODE_STOP);
        chk({modeNow, wakeSource}, {SWW_STOP, 3'h0});
        csPin_b <= 1'b0;
        step(3);
        csPin_b <= 1'b1;
        for (n = 0; n < 50 && modeNow === SWW_STOP; n++)
            step(1);
        step(2);
        chk({n < 50, intSource[6], wakeSource, irqPin_b}, 6'h21);
        $display("wake done");
    endtask
    initial
    begin
        {rst_b, cause, txdStuckIn, rxdShortIn, regLowIn, regOverTempIn, wdConfOpenIn} = '0;
        {linDominantIn, modeWrite, cyclicSelect, linStatusRead, wakeStatusRead, holdLow} = '0;
        {ackOn, wakeIn, wakeEnable, muxSelect, modeBits, periodSelect, wdPrescale, hsEnable} = '0;
        {wdConfGndIn, csPin_b, intEnable} = 9'h1ff;
        step(5);
        rst_b <= 1'b1;
        for (n = 0; n < 100 && modeNow !== SWW_NORMAL; n++)
            step(1);
        chk({n >= 20, wdOffFlag, wdFaultFlag, rstPinOut}, 4'hc);
        t_irq();
        t_ext();
        t_sleep();
        results();
    end
endmodule // supervisor_wakeup_watchdog_test
